// ===== shared/clk_seq_pkg.sv
package clk_seq_pkg;

  // Register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFF_PWR_CTL = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;

  // Power-management control field layout
  localparam int unsigned MULT_W   = 6;
  localparam int unsigned MULT_LSB = 0;
  localparam int unsigned DIV_LSB  = 6;
  localparam int unsigned DIV_W    = 2;
  localparam int unsigned HALV_BIT = 8;
  localparam int unsigned PWR_CTL_W = 9;

  // Status field layout
  localparam int unsigned ST_RUN_BIT  = 0;
  localparam int unsigned ST_LOCK_BIT = 1;
  localparam int unsigned ST_BOOT_LSB = 2;
  localparam int unsigned ST_CFG_LSB  = 4;

  // Values after reset
  localparam logic [DIV_W-1:0] DIV_CODE_RESET = 2'h0;
  localparam logic             HALV_RESET     = 1'h0;
  localparam logic [1:0]       STRAP_RESET    = 2'h0;

  // Start-up multiplier chosen by the ratio straps
  localparam logic [MULT_W-1:0] MULT_CFG0 = 6'h10;
  localparam logic [MULT_W-1:0] MULT_CFG1 = 6'h20;
  localparam logic [MULT_W-1:0] MULT_CFG2 = 6'h08;
  localparam logic [MULT_W-1:0] MULT_CFG3 = 6'h10;

  // Ratio output widths
  localparam int unsigned OSC_W = MULT_W + 1;
  localparam int unsigned DVAL_W = 4;
  localparam int unsigned DEN_W = DVAL_W + 1;
  localparam logic [DVAL_W-1:0] DIV_FORCED = 4'h1;

  // Lock interval in reference-clock cycles
  localparam int unsigned LOCK_CYCLES = 4096;
  localparam int unsigned LOCK_W      = 12;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_LOCK = 2'b01,
    ST_RUN  = 2'b11
  } seq_state_t;

endpackage

// ===== shared/clk_seq_if.sv
`timescale 1ns/1ps
interface clk_seq_if;
  import clk_seq_pkg::*;
  logic                     lock_start;
  logic                     lock_abort;
  logic                     lock_done;
  logic [MULT_W-1:0]        mult;
  logic [DIV_W-1:0]         div_code;
  logic                     halver;
  logic                     force_one;
  logic [OSC_W-1:0]         osc_mult;
  logic [DVAL_W-1:0]        divider;
  logic [DEN_W-1:0]         core_denom;

  modport ctrl (output lock_start, lock_abort, mult, div_code, halver,
                force_one,
                input lock_done, osc_mult, divider, core_denom);
  modport lock (input lock_start, lock_abort, output lock_done);
  modport ratio (input mult, div_code, halver, force_one,
                 output osc_mult, divider, core_denom);
endinterface

// ===== verilog/lock_counter.sv
`timescale 1ns/1ps
module lock_counter
  import clk_seq_pkg::*;
(
  input  wire logic clk_sys_in,
  input  wire logic reset_in,
  input  wire logic ce_in,
  clk_seq_if.lock   seq
);
  logic [LOCK_W-1:0] count;
  logic              busy;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      count <= '0;
      busy  <= 1'b0;
    end else if (ce_in) begin
      if (seq.lock_abort) begin
        busy <= 1'b0;
      end else if (seq.lock_start) begin
        count <= LOCK_W'(LOCK_CYCLES - 1);
        busy  <= 1'b1;
      end else if (busy) begin
        if (count == '0) begin
          busy <= 1'b0;
        end else begin
          count <= count - 1'b1;
        end
      end
    end
  end

  // Seen by the sequencer in the same cycle it is raised
  assign seq.lock_done = busy && (count == '0) && !seq.lock_abort;
endmodule

// ===== verilog/pll_ratio.sv
`timescale 1ns/1ps
module pll_ratio
  import clk_seq_pkg::*;
(
  input  wire logic clk_sys_in,
  input  wire logic reset_in,
  input  wire logic ce_in,
  clk_seq_if.ratio  seq
);
  logic [DVAL_W-1:0] next_divider;

  always_comb begin
    unique case (seq.div_code)
      2'h0: next_divider = 4'h1;
      2'h1: next_divider = 4'h2;
      2'h2: next_divider = 4'h4;
      2'h3: next_divider = 4'h8;
    endcase
    if (seq.force_one) begin
      next_divider = DIV_FORCED;
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      seq.osc_mult   <= '0;
      seq.divider    <= DIV_FORCED;
      seq.core_denom <= {DIV_FORCED, 1'b0};
    end else if (ce_in) begin
      // oscillator is twice multiplier times input
      seq.osc_mult   <= seq.halver ? {1'b0, seq.mult} : {seq.mult, 1'b0};
      // core is oscillator over twice divider
      seq.core_denom <= {next_divider, 1'b0};
      seq.divider    <= next_divider;
    end
  end
endmodule

// ===== verilog/pll_clock_reset_sequencer.sv
// Overview of operation
// - After reset release wait 4096 reference cycles, then start the core.
// - Core reset drives the reset-out pin: low in reset, high after.
// - Ratio straps pick the start-up multiplier, used while reset is active.
// - Software may rewrite multiplier and divider any time after reset.
// - Oscillator is 2 x multiplier x input; core is oscillator over 2 x divider.
// - Divider is 1, 2, 4 or 8 per the programmed divider field.
// - During reset the divider is forced to 1.
// - Halver enabled halves the reference into the oscillator input.
`timescale 1ns/1ps
module pll_clock_reset_sequencer
  import clk_seq_pkg::*;
(
  input  wire logic                       clk_sys_in,
  input  wire logic                       reset_in,
  input  wire logic                       ce_in,
  input  wire logic                       ext_reset_n_in,
  input  wire logic [1:0]                 clk_cfg_in,
  input  wire logic [1:0]                 boot_cfg_in,
  input  wire logic [clk_seq_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [clk_seq_pkg::DATA_W-1:0] wdata_in,
  input  wire logic                       wr_in,
  input  wire logic                       rd_in,
  output logic [clk_seq_pkg::DATA_W-1:0]  rdata_out,
  output logic                            core_reset_output_n_out,
  output logic                            core_reset_out,
  output logic [1:0]                      boot_mode_out,
  output logic [clk_seq_pkg::MULT_W-1:0]  pll_multiplier_out,
  output logic [clk_seq_pkg::DVAL_W-1:0]  pll_divider_out,
  output logic                            input_halver_enable_out,
  output logic [clk_seq_pkg::OSC_W-1:0]   osc_ratio_out,
  output logic [clk_seq_pkg::DEN_W-1:0]   core_ratio_den_out
);
  import clk_seq_pkg::*;

  clk_seq_if seq ();

  seq_state_t        state;
  seq_state_t        next_state;
  logic [1:0]        rst_pin_sync;
  logic [1:0]        cfg_meta;
  logic [1:0]        cfg_sync;
  logic [1:0]        boot_meta;
  logic [1:0]        boot_sync;
  logic [1:0]        clk_cfg_held;
  logic [MULT_W-1:0] pll_multiplier;
  logic [DIV_W-1:0]  pll_divider;
  logic              input_halver_enable;
  logic [MULT_W-1:0] strap_mult;
  logic              pin_released;
  logic              pwr_ctl_wr;

  // Pins come from outside the clock domain
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      rst_pin_sync <= 2'h0;
    end else if (ce_in) begin
      rst_pin_sync <= {rst_pin_sync[0], ext_reset_n_in};
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      cfg_meta  <= STRAP_RESET;
      cfg_sync  <= STRAP_RESET;
      boot_meta <= STRAP_RESET;
      boot_sync <= STRAP_RESET;
    end else if (ce_in) begin
      cfg_meta  <= clk_cfg_in;
      cfg_sync  <= cfg_meta;
      boot_meta <= boot_cfg_in;
      boot_sync <= boot_meta;
    end
  end

  // Only the second stage is read
  assign pin_released = rst_pin_sync[1];

  // straps tracked while reset pin is low, frozen at release
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      boot_mode_out <= STRAP_RESET;
      clk_cfg_held  <= STRAP_RESET;
    end else if (ce_in && state == ST_HOLD && !pin_released) begin
      boot_mode_out <= boot_sync;
      clk_cfg_held  <= cfg_sync;
    end
  end

  always_comb begin
    unique case (cfg_sync)
      2'h0: strap_mult = MULT_CFG0;
      2'h1: strap_mult = MULT_CFG1;
      2'h2: strap_mult = MULT_CFG2;
      2'h3: strap_mult = MULT_CFG3;
    endcase
  end

  // pin low means hold, whatever state we were in
  always_comb begin
    next_state = state;
    unique case (state)
      ST_HOLD: begin
        if (pin_released) begin
          next_state = ST_LOCK;
        end
      end
      ST_LOCK: begin
        if (!pin_released) begin
          next_state = ST_HOLD;
        end else if (seq.lock_done) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!pin_released) begin
          next_state = ST_HOLD;
        end
      end
      default: next_state = ST_HOLD;
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      state <= ST_HOLD;
    end else if (ce_in) begin
      state <= next_state;
    end
  end

  assign seq.lock_start = (state == ST_HOLD) && pin_released;
  assign seq.lock_abort = !pin_released;

  lock_counter u_lock (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .ce_in      (ce_in),
    .seq        (seq)
  );

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      core_reset_output_n_out <= 1'b0;
      core_reset_out          <= 1'b1;
    end else if (ce_in) begin
      core_reset_output_n_out <= (next_state == ST_RUN);
      core_reset_out          <= (next_state != ST_RUN);
    end
  end

  // writes count only once the core runs
  assign pwr_ctl_wr = wr_in && (addr_in == OFF_PWR_CTL) && (state == ST_RUN);

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      pll_multiplier      <= MULT_CFG0;
      pll_divider         <= DIV_CODE_RESET;
      input_halver_enable <= HALV_RESET;
    end else if (ce_in) begin
      if (state != ST_RUN) begin
        pll_multiplier      <= strap_mult;
        pll_divider         <= DIV_CODE_RESET;
        input_halver_enable <= HALV_RESET;
      end else if (pwr_ctl_wr) begin
        pll_multiplier      <= wdata_in[MULT_LSB +: MULT_W];
        pll_divider         <= wdata_in[DIV_LSB +: DIV_W];
        input_halver_enable <= wdata_in[HALV_BIT];
      end
    end
  end

  // no clamp; an illegal product is software's to avoid
  assign seq.mult      = pll_multiplier;
  assign seq.div_code  = pll_divider;
  assign seq.halver    = input_halver_enable;
  // divider forced while core in reset
  assign seq.force_one = (state != ST_RUN);

  pll_ratio u_ratio (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .ce_in      (ce_in),
    .seq        (seq)
  );

  assign pll_divider_out    = seq.divider;
  assign osc_ratio_out      = seq.osc_mult;
  assign core_ratio_den_out = seq.core_denom;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      pll_multiplier_out      <= MULT_CFG0;
      input_halver_enable_out <= HALV_RESET;
    end else if (ce_in) begin
      pll_multiplier_out      <= pll_multiplier;
      input_halver_enable_out <= input_halver_enable;
    end
  end

  // Read data stands the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_out <= '0;
    end else if (ce_in) begin
      rdata_out <= '0;
      if (rd_in && addr_in == OFF_PWR_CTL) begin
        rdata_out[PWR_CTL_W-1:0] <= {input_halver_enable, pll_divider,
                                   pll_multiplier};
      end else if (rd_in && addr_in == OFF_STATUS) begin
        rdata_out[ST_RUN_BIT]         <= (state == ST_RUN);
        rdata_out[ST_LOCK_BIT]        <= (state == ST_LOCK);
        rdata_out[ST_BOOT_LSB +: 2]   <= boot_mode_out;
        rdata_out[ST_CFG_LSB +: 2]    <= clk_cfg_held;
      end
    end
  end

  // Helper: cycles spent in the lock state
  logic [LOCK_W:0] lock_len;
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      lock_len <= '0;
    end else if (ce_in) begin
      lock_len <= (state == ST_LOCK) ? lock_len + 1'b1 : '0;
    end
  end

  sequence s_run_steady;
    ce_in && state == ST_RUN ##1 ce_in && state == ST_RUN;
  endsequence

  sequence s_held_steady;
    ce_in && state != ST_RUN ##1 ce_in && state != ST_RUN;
  endsequence

  property p_lock_len;
    @(posedge clk_sys_in) disable iff (reset_in)
      $rose(state == ST_RUN) |-> $past(lock_len) == (LOCK_CYCLES - 1);
  endproperty
  a_lock_len: assert property (p_lock_len)
    else $error("core started without a full lock interval");

  property p_rst_out;
    @(posedge clk_sys_in) disable iff (reset_in)
      core_reset_output_n_out == (state == ST_RUN) &&
      core_reset_out == !core_reset_output_n_out;
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("reset-out does not follow core reset");

  property p_pin_hold;
    @(posedge clk_sys_in) disable iff (reset_in)
      ce_in && !pin_released |=> !core_reset_output_n_out;
  endproperty
  a_pin_hold: assert property (p_pin_hold)
    else $error("reset-out high while reset pin low");

  property p_lock_low;
    @(posedge clk_sys_in) disable iff (reset_in)
      ce_in && state == ST_LOCK && !seq.lock_done |=> core_reset_out;
  endproperty
  a_lock_low: assert property (p_lock_low)
    else $error("core released during lock");

  property p_strap_mult;
    @(posedge clk_sys_in) disable iff (reset_in)
      ce_in && state != ST_RUN |=> pll_multiplier == $past(strap_mult);
  endproperty
  a_strap_mult: assert property (p_strap_mult)
    else $error("multiplier not taken from straps in reset");

  property p_write_run;
    @(posedge clk_sys_in) disable iff (reset_in)
      ce_in && pwr_ctl_wr |=>
        {input_halver_enable, pll_divider, pll_multiplier} ==
        $past(wdata_in[PWR_CTL_W-1:0]);
  endproperty
  a_write_run: assert property (p_write_run)
    else $error("control write after reset not stored");

  property p_div_force;
    @(posedge clk_sys_in) disable iff (reset_in)
      s_held_steady |-> pll_divider_out == DIV_FORCED;
  endproperty
  a_div_force: assert property (p_div_force)
    else $error("divider not forced to one in reset");

  property p_div_map;
    @(posedge clk_sys_in) disable iff (reset_in)
      s_run_steady |-> pll_divider_out == (4'h1 << $past(pll_divider));
  endproperty
  a_div_map: assert property (p_div_map)
    else $error("divider value does not match field");

  property p_osc;
    @(posedge clk_sys_in) disable iff (reset_in)
      $past(ce_in) && !$past(reset_in) |->
        osc_ratio_out == ($past(input_halver_enable) ?
        {1'b0, $past(pll_multiplier)} : {$past(pll_multiplier), 1'b0});
  endproperty
  a_osc: assert property (p_osc)
    else $error("oscillator ratio wrong for halver setting");

  property p_core_den;
    @(posedge clk_sys_in) disable iff (reset_in)
      core_ratio_den_out == {pll_divider_out, 1'b0};
  endproperty
  a_core_den: assert property (p_core_den)
    else $error("core ratio is not oscillator over twice divider");

endmodule

// ===== testbench/ext_reset_source.sv
`timescale 1ns/1ps
module ext_reset_source (
  input  wire logic       clk_in,
  input  wire logic       hold_in,
  input  wire logic [1:0] ratio_in,
  input  wire logic [1:0] boot_in,
  output logic            ext_reset_n_out,
  output logic [1:0]      clk_cfg_out,
  output logic [1:0]      boot_cfg_out
);
  assign clk_cfg_out  = ratio_in;
  assign boot_cfg_out = boot_in;

  initial ext_reset_n_out = 1'b0;

  // Pin follows the request one cycle late, so straps settle before it
  always @(posedge clk_in) begin
    ext_reset_n_out <= ~hold_in;
  end
endmodule

// ===== testbench/tb_pll_clock_reset_sequencer.sv
`timescale 1ns/1ps
module tb_pll_clock_reset_sequencer;
  import clk_seq_pkg::*;
  logic              clk_sys_in;
  logic              reset_in;
  logic              ce_in;
  logic              hold;
  logic [1:0]        ratio_sel;
  logic [1:0]        boot_sel;
  logic              ext_reset_n;
  logic [1:0]        clk_cfg;
  logic [1:0]        boot_cfg;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic              rst_out_n;
  logic              core_rst;
  logic [1:0]        boot_mode;
  logic [MULT_W-1:0] mult;
  logic [DVAL_W-1:0] div;
  logic              halv;
  logic [OSC_W-1:0]  osc;
  logic [DEN_W-1:0]  den;
  int                n_errors;
  int                check_count;

  ext_reset_source model (
    .clk_in          (clk_sys_in),
    .hold_in         (hold),
    .ratio_in        (ratio_sel),
    .boot_in         (boot_sel),
    .ext_reset_n_out (ext_reset_n),
    .clk_cfg_out     (clk_cfg),
    .boot_cfg_out    (boot_cfg)
  );

  pll_clock_reset_sequencer uut (
    .clk_sys_in              (clk_sys_in),
    .reset_in                (reset_in),
    .ce_in                   (ce_in),
    .ext_reset_n_in          (ext_reset_n),
    .clk_cfg_in              (clk_cfg),
    .boot_cfg_in             (boot_cfg),
    .addr_in                 (addr),
    .wdata_in                (wdata),
    .wr_in                   (wr),
    .rd_in                   (rd),
    .rdata_out               (rdata),
    .core_reset_output_n_out (rst_out_n),
    .core_reset_out          (core_rst),
    .boot_mode_out           (boot_mode),
    .pll_multiplier_out      (mult),
    .pll_divider_out         (div),
    .input_halver_enable_out (halv),
    .osc_ratio_out           (osc),
    .core_ratio_den_out      (den)
  );

  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [MULT_W-1:0] strap_mult(input logic [1:0] s);
    case (s)
      2'h0:    return MULT_CFG0;
      2'h1:    return MULT_CFG1;
      2'h2:    return MULT_CFG2;
      default: return MULT_CFG3;
    endcase
  endfunction

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic t_straps;
    for (int i = 0; i < 4; i++) begin
      ratio_sel <= 2'(i);
      repeat (6) @(posedge clk_sys_in);
      #1;
      check("strap mult", 32'(mult), 32'(strap_mult(2'(i))));
      check("div in reset", 32'(div), 32'h1);
      check("den in reset", 32'(den), 32'h2);
      check("reset pin", 32'(rst_out_n), 32'h0);
    end
  endtask

  // Releases the pin and times the lock interval
  task automatic t_lock(input logic [1:0] r, input logic [1:0] b);
    int   n;
    logic split;
    logic [31:0] d;
    n = 0;
    split = 1'b0;
    ratio_sel <= r;
    repeat (6) @(posedge clk_sys_in);
    hold <= 1'b0;
    while (rst_out_n !== 1'b1 && n < 5000) begin
      @(posedge clk_sys_in);
      #1;
      n++;
      if (rst_out_n !== 1'b1 && core_rst !== 1'b1) split = 1'b1;
    end
    // Model, two sync stages and the step into lock add 4 edges
    check("lock span", 32'(n), 32'(LOCK_CYCLES + 4));
    check("held through lock", 32'(split), 32'h0);
    check("core reset off", 32'(core_rst), 32'h0);
    check("boot latch", 32'(boot_mode), 32'(b));
    check("run mult", 32'(mult), 32'(strap_mult(r)));
    bus_read(OFF_STATUS, d);
    check("status", d & 32'h3f, {26'h0, r, b, 2'b01});
    @(posedge clk_sys_in);
    #1;
    check("rdata idle", rdata, 32'h0);
  endtask

  task automatic t_pwr_ctl;
    logic [5:0]  m;
    logic [31:0] d;
    // small multipliers keep every product under the oscillator limit
    for (int c = 0; c < 4; c++) begin
      for (int h = 0; h < 2; h++) begin
        m = 6'h05 + 6'(c * 9);
        bus_write(OFF_PWR_CTL, {23'h0, 1'(h), 2'(c), m});
        repeat (2) @(posedge clk_sys_in);
        #1;
        check("mult", 32'(mult), 32'(m));
        check("div", 32'(div), 32'(1 << c));
        check("den", 32'(den), 32'(2 << c));
        check("halver", 32'(halv), 32'(h));
        check("osc", 32'(osc), h ? 32'(m) : 32'(m) * 2);
        bus_read(OFF_PWR_CTL, d);
        check("pwr ctl back", d, {23'h0, 1'(h), 2'(c), m});
      end
    end
    bus_read(8'h10, d);
    check("unmapped", d, 32'h0);
  endtask

  // Clock enable low: a write in that span must be lost
  task automatic t_freeze;
    @(posedge clk_sys_in);
    ce_in <= 1'b0;
    bus_write(OFF_PWR_CTL, 32'h047);
    repeat (2) @(posedge clk_sys_in);
    #1;
    check("frozen mult", 32'(mult), 32'h20);
    check("frozen div", 32'(div), 32'h8);
    @(posedge clk_sys_in);
    ce_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    #1;
    check("write dropped", 32'(mult), 32'h20);
    check("still running", 32'(core_rst), 32'h0);
  endtask

  // Pin pulled low mid-run, with divider code 3 programmed
  task automatic t_drop;
    // boot straps settle before the pin is pulled low
    boot_sel <= 2'h1;
    @(posedge clk_sys_in);
    hold <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
    #1;
    check("pin low out", 32'(rst_out_n), 32'h0);
    check("core reset on", 32'(core_rst), 32'h1);
    check("forced div", 32'(div), 32'h1);
    check("forced den", 32'(den), 32'h2);
    bus_write(OFF_PWR_CTL, 32'h1ff);
    repeat (3) @(posedge clk_sys_in);
    #1;
    check("write ignored", 32'(mult), 32'(strap_mult(ratio_sel)));
    check("div kept", 32'(div), 32'h1);
  endtask

  initial begin
    n_errors    = 0;
    check_count = 0;
    reset_in    = 1'b1;
    ce_in       = 1'b1;
    hold        = 1'b1;
    ratio_sel   = 2'h0;
    boot_sel    = 2'h2;
    addr        = '0;
    wdata       = '0;
    wr          = 1'b0;
    rd          = 1'b0;
    repeat (2) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    t_straps();
    t_lock(2'h1, 2'h2);
    t_pwr_ctl();
    t_freeze();
    t_drop();
    t_lock(2'h2, 2'h1);
    print_verdict();
  end

  // Two lock intervals plus bus work fit well inside this span
  initial begin
    repeat (30000) @(posedge clk_sys_in);
    n_errors++;
    print_verdict();
  end
endmodule
